/* File: ics_idle_slowdown.v */
`timescale 1ns/1ps
`include "ics_defs.vh"
// Contract
// - in idle the cpu clock enable is held low so no instruction runs.
// - entering idle pulses a clear to the watchdog timer count.
// - in idle the system clock keeps running and peripherals keep clocks unless disabled.
// - in idle the low power rc oscillator stays on if watchdog or clock monitor is enabled.
// - idle ends on an enabled interrupt, any reset or a watchdog time-out.
// - after wake the cpu clock returns within two to four cycles.
// - an interrupt during the power save instruction is held and wakes at once after entry.
// - in slowdown only the cpu clock is divided, peripherals stay full speed.
// - divided cpu enables are aligned to system clock edges so domains stay in step.
// - bit 11 of the clock divider register enables slowdown.
// - bits 14:12 select ratio 1:1 to 1:128, reset default 1:1.
// - with bit 15 set an interrupt switches the cpu back to full speed.
// - with bit 15 clear interrupts leave the ratio unchanged.
// - a peripheral disable bit stops or restarts its clock one cycle later.
module ics_idle_slowdown #(
  parameter NPER = 8
) (
  // clock and reset
  input wire clk_in,
  input wire rstn_in,
  // cpu side
  input wire pwrsave_exec_in,
  input wire pwrsave_idle_sel_in,
  input wire irq_pending_in,
  // clock divider register write
  input wire cdr_wr_in,
  input wire [15:0] cdr_wdata_in,
  // watchdog and monitor
  input wire wdt_enable_in,
  input wire wdt_timeout_in,
  input wire fail_safe_clock_monitor_enable_in,
  // peripheral disable bits
  input wire [NPER-1:0] pmd_in,
  // clocking and status outputs
  output reg cpu_clk_en_out,
  output reg idle_out,
  output reg wdt_clear_out,
  output reg low_power_rc_oscillator_on_out,
  output reg sys_clk_on_out,
  output reg [15:0] cdr_out,
  output reg wake_out,
  output wire [NPER-1:0] per_clk_en_out
);
  localparam ST_RUN = 4'b0001;
  localparam ST_IDLE = 4'b0010;
  localparam ST_WAKE = 4'b0100;
  localparam ST_HOLD = 4'b1000;

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [2:0] wcnt_r;
  reg held_irq_r;
  reg [15:0] cdr_nxt;
  wire slow_en;
  wire return_on_interrupt;
  wire [2:0] ratio;
  wire div_tick;
  wire run_en;
  wire irq_wake;

  assign slow_en = cdr_r_bit(cdr_out, `ICS_CDR_SLOW_EN_BIT);
  assign return_on_interrupt = cdr_r_bit(cdr_out, `ICS_CDR_ROI_BIT);
  assign ratio = cdr_out[`ICS_CDR_RATIO_MSB:`ICS_CDR_RATIO_LSB];

  function cdr_r_bit;
    input [15:0] v;
    input integer b;
    begin
      cdr_r_bit = v[b];
    end
  endfunction

  ics_ratio_div #(.RW(3)) u_div (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .ratio_in(ratio),
    .restart_in(cdr_wr_in),
    .tick_out(div_tick)
  );

  genvar g;
  generate
    for (g = 0; g < NPER; g = g + 1) begin : g_pmd
      ics_pmd_gate u_gate (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .disable_in(pmd_in[g]),
        .clk_en_out(per_clk_en_out[g])
      );
    end
  endgenerate

  // idle wake sources; resets act through rstn_in
  assign irq_wake = irq_pending_in | held_irq_r | wdt_timeout_in;

  // only the cpu enable is divided, full speed when slowdown is off
  assign run_en = slow_en ? div_tick : 1'b1;

  // clock divider register write and return-on-interrupt
  always @* begin
    cdr_nxt = cdr_out;
    if (cdr_wr_in) begin
      cdr_nxt = cdr_wdata_in & 16'hF800;
    end
    // drop back to full speed on interrupt
    if (return_on_interrupt && irq_pending_in) begin
      cdr_nxt[`ICS_CDR_SLOW_EN_BIT] = 1'b0;
    end
    // without roi the ratio and enable stand as written
  end

  // state transitions
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        // idle only from the power save instruction with idle selected
        if (pwrsave_exec_in && pwrsave_idle_sel_in) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // entry completes first, then any held interrupt wakes
        state_nxt = irq_wake ? ST_WAKE : ST_IDLE;
      end
      ST_IDLE: begin
        // wake on enabled interrupt or watchdog time-out
        if (irq_wake) begin
          state_nxt = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // fixed latency inside the two to four cycle window
        if (wcnt_r == 3'd`ICS_WAKE_DLY - 3'd1) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  // sequential state, counters and outputs
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= ST_RUN;
      wcnt_r <= 3'd0;
      held_irq_r <= 1'b0;
      cdr_out <= `ICS_CDR_RESET;
      cpu_clk_en_out <= 1'b1;
      idle_out <= 1'b0;
      wdt_clear_out <= 1'b0;
      low_power_rc_oscillator_on_out <= 1'b0;
      sys_clk_on_out <= 1'b1;
      wake_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // ratio field held in the register, default 1:1
      cdr_out <= cdr_nxt;
      wcnt_r <= (state_r == ST_WAKE) ? wcnt_r + 3'd1 : 3'd0;
      // latch an interrupt that arrives with the instruction
      if (state_r == ST_RUN && pwrsave_exec_in && pwrsave_idle_sel_in) begin
        held_irq_r <= irq_pending_in;
      end else if (state_r == ST_HOLD) begin
        held_irq_r <= 1'b0;
      end
      // gate the cpu clock outside run state
      cpu_clk_en_out <= (state_nxt == ST_RUN) & run_en;
      idle_out <= (state_nxt != ST_RUN);
      // clear the watchdog on idle entry
      wdt_clear_out <= (state_r == ST_RUN) && (state_nxt == ST_HOLD);
      // keep the rc oscillator running while it is needed
      low_power_rc_oscillator_on_out <= wdt_enable_in | fail_safe_clock_monitor_enable_in;
      // system clock never stops in idle or slowdown
      sys_clk_on_out <= 1'b1;
      wake_out <= (state_r == ST_WAKE) && (state_nxt == ST_RUN);
    end
  end
endmodule // ics_idle_slowdown

/* File: ics_defs.vh */
`ifndef ICS_DEFS_VH
`define ICS_DEFS_VH
// clock divider register field positions
`define ICS_CDR_SLOW_EN_BIT 11
`define ICS_CDR_RATIO_LSB 12
`define ICS_CDR_RATIO_MSB 14
`define ICS_CDR_ROI_BIT 15
// reset value of the clock divider register (ratio 1:1, all off)
`define ICS_CDR_RESET 16'h0000
// wake-up latency in clock cycles
`define ICS_WAKE_MIN 2
`define ICS_WAKE_MAX 4
`define ICS_WAKE_DLY 3
// peripheral disable latency, one instruction cycle
`define ICS_PMD_DLY 1
`endif

/* File: ics_ratio_div.v */
`timescale 1ns/1ps
// divides by 2**ratio_in, giving one enable pulse per period
module ics_ratio_div #(
  parameter RW = 3
) (
  // clock and reset
  input wire clk_in,
  input wire rstn_in,
  // control
  input wire [RW-1:0] ratio_in,
  input wire restart_in,
  // tick out
  output reg tick_out
);
  reg [7:0] cnt_r;
  wire [7:0] limit;
  // all-ones mask of the selected length
  assign limit = (8'h01 << ratio_in) - 8'h01;
  // free running counter, restarts on request so the cpu edge stays aligned
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_r <= 8'h00;
      tick_out <= 1'b0;
    end else if (restart_in) begin
      cnt_r <= 8'h00;
      tick_out <= 1'b1;
    end else begin
      tick_out <= (cnt_r >= limit);
      cnt_r <= (cnt_r >= limit) ? 8'h00 : cnt_r + 8'h01;
    end
  end
endmodule // ics_ratio_div

/* File: ics_pmd_gate.v */
`timescale 1ns/1ps
`include "ics_defs.vh"
// one instance per peripheral: enable follows the disable bit one cycle later
module ics_pmd_gate (
  // clock and reset
  input wire clk_in,
  input wire rstn_in,
  // disable bit
  input wire disable_in,
  // clock enable toward the peripheral
  output reg clk_en_out
);
  // registered so the change lands one instruction cycle after the write
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clk_en_out <= 1'b1;
    end else begin
      clk_en_out <= ~disable_in;
    end
  end
endmodule // ics_pmd_gate

/* File: ics_core_model.sv */
`timescale 1ns/1ps
// stand-in for the core: counts the cycles its clock really ticks
module ics_core_model (
  // clock and reset
  input wire clk_in,
  input wire rstn_in,
  // cpu clock enable from the block
  input wire cpu_clk_en_in,
  // executed cycle count
  output reg [15:0] ticks_out
);
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) ticks_out <= 16'h0000;
    else if (cpu_clk_en_in) ticks_out <= ticks_out + 16'h0001;
  end
endmodule // ics_core_model

/* File: ics_idle_slowdown_sva.sv */
`timescale 1ns/1ps
// ties each clocking output except sys_clk_on_out to its cause
module ics_idle_slowdown_sva #(parameter NPER = 8) (
  // inputs of the block
  input wire clk_in,
  input wire rstn_in,
  input wire pwrsave_exec_in,
  input wire pwrsave_idle_sel_in,
  input wire irq_pending_in,
  input wire cdr_wr_in,
  input wire [15:0] cdr_wdata_in,
  input wire wdt_enable_in,
  input wire fail_safe_clock_monitor_enable_in,
  input wire [NPER-1:0] pmd_in,
  // outputs of the block
  input wire cpu_clk_en_out,
  input wire idle_out,
  input wire wdt_clear_out,
  input wire low_power_rc_oscillator_on_out,
  input wire [15:0] cdr_out,
  input wire wake_out,
  input wire [NPER-1:0] per_clk_en_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  chk_idle_gates_cpu: assert property (idle_out && !wake_out |-> !cpu_clk_en_out)
    else $error("cpu ticks while idle");
  chk_entry_clears_wdt: assert property ($rose(idle_out) |-> wdt_clear_out)
    else $error("no watchdog clear at idle entry");
  chk_low_power_rc_oscillator_kept: assert property (wdt_enable_in || fail_safe_clock_monitor_enable_in |=> low_power_rc_oscillator_on_out)
    else $error("rc oscillator dropped");
  chk_irq_wakes: assert property ($rose(irq_pending_in) && idle_out |-> ##[1:6] wake_out)
    else $error("no wake on interrupt");
  chk_cmd_enters: assert property (pwrsave_exec_in && pwrsave_idle_sel_in && !idle_out |=> idle_out)
    else $error("idle not entered");
  chk_cdr_write: assert property (cdr_wr_in && !irq_pending_in |=> cdr_out == {$past(cdr_wdata_in[15:11]), 11'h000})
    else $error("divider register write wrong");
  chk_roi_return: assert property (cdr_out[15] && irq_pending_in && !cdr_wr_in |=> !cdr_out[11])
    else $error("no return to full speed");
  chk_pmd_delay: assert property (1 |=> per_clk_en_out == ~$past(pmd_in))
    else $error("peripheral enable late");
endmodule // ics_idle_slowdown_sva
bind ics_idle_slowdown ics_idle_slowdown_sva #(.NPER(NPER)) ics_idle_slowdown_sva_inst (.*);

/* File: ics_idle_slowdown_tb.sv */
`timescale 1ns/1ps
module ics_idle_slowdown_tb;
  reg clk_in = 0;
  reg rstn_in = 0;
  reg px = 0, ps = 0, irq = 0, wr = 0, we = 0, wt = 0, fe = 0;
  reg [15:0] wd = 16'h0000;
  reg [7:0] pmd = 8'h00;
  wire cke, idl, wclr, low_power_rc_oscillator, son, wk;
  wire [15:0] cdr, ticks;
  wire [7:0] pce;
  integer n_mismatch = 0, tests_run = 0, r, n;
  reg [15:0] t0;
  always #2.5 clk_in = ~clk_in;
  ics_idle_slowdown ics_idle_slowdown_inst (.clk_in(clk_in), .rstn_in(rstn_in),
    .pwrsave_exec_in(px), .pwrsave_idle_sel_in(ps), .irq_pending_in(irq), .cdr_wr_in(wr),
    .cdr_wdata_in(wd), .wdt_enable_in(we), .wdt_timeout_in(wt), .fail_safe_clock_monitor_enable_in(fe),
    .pmd_in(pmd), .cpu_clk_en_out(cke), .idle_out(idl), .wdt_clear_out(wclr),
    .low_power_rc_oscillator_on_out(low_power_rc_oscillator), .sys_clk_on_out(son), .cdr_out(cdr), .wake_out(wk),
    .per_clk_en_out(pce));
  ics_core_model ics_core_model_inst (.clk_in(clk_in), .rstn_in(rstn_in),
    .cpu_clk_en_in(cke), .ticks_out(ticks));
  task cyc(input integer k);
    repeat (k) @(negedge clk_in);
  endtask
  task cmp(input string nm, input [15:0] e, input [15:0] g);
    begin
      tests_run = tests_run + 1;
      if (e !== g) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  // h: interrupt held with the instruction, w: wake by watchdog time-out
  task t_idle(input h, input w);
    begin
      irq = h;
      px = 1;
      ps = 1;
      cyc(1);
      px = 0;
      cmp("idle", 1, idl);
      cmp("wclr", 1, wclr);
      if (!h) cyc(3);
      if (!h) cmp("gate", 0, cke);
      // a held interrupt must wake on its own, so the live request drops
      irq = !w && !h;
      wt = w;
      n = 0;
      while (!wk && n < 8) begin
        cyc(1);
        n = n + 1;
      end
      if (n == 8) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch wake exp 1 got 0");
        complete_run;
      end
      cmp("wlat", 1, (h || n >= 2) && n <= 4);
      cmp("cpu", 1, cke);
      irq = 0;
      wt = 0;
      cyc(2);
      cmp("run", 0, idl);
      $display("test idle done");
    end
  endtask
  task wr_cdr(input [15:0] v);
    begin
      wd = v;
      wr = 1;
      cyc(1);
      wr = 0;
    end
  endtask
  // counts core ticks over k cycles
  task t_rate(input integer k, input [15:0] e);
    begin
      t0 = ticks;
      cyc(k);
      cmp("ticks", e, ticks - t0);
    end
  endtask
  task t_doze;
    for (r = 0; r < 8; r = r + 1) begin
      wr_cdr({1'b0, r[2:0], 12'hFFF});
      cmp("cdr", {1'b0, r[2:0], 12'h800}, cdr);
      // skip the edge that still carries the old ratio's enable
      cyc(1);
      t_rate(4 << r, 16'h0004);
    end
    $display("test ratio done");
  endtask
  task t_roi;
    begin
      wr_cdr(16'hB800);
      irq = 1;
      cyc(1);
      irq = 0;
      cmp("roi", 16'hB000, cdr);
      t_rate(4, 16'h0004);
      wr_cdr(16'h2800);
      irq = 1;
      cyc(1);
      irq = 0;
      cmp("keep", 16'h2800, cdr);
      t_rate(8, 16'h0002);
      $display("test doze done");
    end
  endtask
  task t_pmd;
    begin
      pmd = 8'hA5;
      we = 1;
      cyc(1);
      cmp("pce", 16'h005A, pce);
      cmp("low_power_rc_oscillator", 1, low_power_rc_oscillator);
      pmd = 8'h00;
      we = 0;
      fe = 1;
      cyc(1);
      cmp("pce", 16'h00FF, pce);
      cmp("low_power_rc_oscillator", 1, low_power_rc_oscillator);
      fe = 0;
      cyc(1);
      cmp("low_power_rc_oscillator", 0, low_power_rc_oscillator);
      cmp("sys", 1, son);
      $display("test pmd done");
    end
  endtask
  initial begin
    cyc(16);
    rstn_in = 1;
    cyc(1);
    t_idle(0, 0);
    t_idle(0, 1);
    t_idle(1, 0);
    t_doze;
    t_roi;
    t_pmd;
    complete_run;
  end
endmodule // ics_idle_slowdown_tb
